// ===== hdl/dps_top.sv
// dps_top: port decode, command/status bus, formatter start and interrupt chain.
// assumes host address and strobes synchronous to i_clk_sys; chain in pulled high.
`timescale 1ns/10ps
module dps_top #(
    parameter int unsigned TIMER_TICKS = dps_pkg::TIMER_PHI2_TICKS,
    parameter int unsigned PHI2_DIV    = dps_pkg::PHI2_DIV_CYCLES
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    input  wire logic [7:0] i_host_addr,
    input  wire logic [7:0] i_host_data,
    input  wire logic       i_port_block_select_n,
    input  wire logic       i_host_rd_n,
    input  wire logic       i_chain_priority_in,
    input  wire logic       i_dma_irq,
    input  wire logic       i_counter_timer_chip_irq,
    input  wire logic       i_parallel_io_chip_irq,
    input  wire logic [3:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    output logic [7:0]      o_reg_rdata,
    output logic [7:0]      o_ext_addr,
    output logic [7:0]      o_drive_cmd,
    output logic            o_status_buf_en,
    output logic            o_read_from_disk,
    output logic            o_write_to_disk,
    output logic            o_transfer_mode_n,
    output logic            o_formatter_go,
    output logic            o_formatter_en,
    output logic            o_bus_int_n,
    output logic            o_chain_priority_out,
    output logic            o_irq
);
    dps_start_if sif ();

    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] ext_q, ext_d;
    logic [7:0] cmd_q, cmd_d;
    localparam int unsigned IRQ_BITS_W = dps_pkg::IRQ_BITS;
    logic [IRQ_BITS_W-1:0] ist_q, ist_d;
    logic [IRQ_BITS_W-1:0] imask_q, imask_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] div_q, div_d;
    logic [15:0] tmr_q, tmr_d;
    logic       tmr_run_q, tmr_run_d;
    logic       rd_prev_q, rd_prev_d;
    logic       gate_prev_q, go_prev_q;
    logic       phi2_tick, terminal, rd_fall, decode_en, porta0, mode_n;
    logic       sel_low, sel_high;

    function automatic logic port_hit(input logic [7:0] a, input logic [7:0] p);
        port_hit = ((a & dps_pkg::PORT_DEC_MASK) == (p & dps_pkg::PORT_DEC_MASK));
    endfunction

    assign mode_n    = ctrl_q[dps_pkg::CTRL_MODE_N_BIT];
    assign porta0    = ctrl_q[dps_pkg::CTRL_PORTA0_BIT];
    assign decode_en = !i_port_block_select_n
                     && port_hit(i_host_addr, dps_pkg::PORT_LOW_ADDR);
    assign sel_low   = decode_en && !i_host_addr[0];
    assign sel_high  = decode_en && i_host_addr[0];
    // strobe edge stands in for the latch clock; keeps one clock domain
    assign rd_fall   = rd_prev_q && !i_host_rd_n;
    assign phi2_tick = (div_q == 8'(PHI2_DIV - 1));
    assign terminal  = tmr_run_q && phi2_tick && (tmr_q == 16'h0001);

    always_comb begin
        ctrl_d    = ctrl_q;
        ext_d     = ext_q;
        cmd_d     = cmd_q;
        imask_d   = imask_q;
        ist_d     = ist_q;
        rdata_d   = 8'h00;
        rd_prev_d = i_host_rd_n;
        div_d     = phi2_tick ? 8'h00 : 8'(div_q + 8'h01);
        tmr_d     = tmr_q;
        tmr_run_d = tmr_run_q;
        if (sel_low && rd_fall) begin
            ext_d = i_host_data;
        end
        if (sel_high && rd_fall && porta0) begin
            cmd_d = i_host_data;
        end
        // timer restarts whenever software arms it while in transfer mode
        if (mode_n) begin
            tmr_run_d = 1'b0;
        end else if (i_reg_wr && i_reg_addr == dps_pkg::REG_CTRL
                     && i_reg_wdata[dps_pkg::CTRL_ARM_BIT]) begin
            tmr_run_d = 1'b1;
            tmr_d     = 16'(TIMER_TICKS);
        end else if (tmr_run_q && phi2_tick) begin
            tmr_d = 16'(tmr_q - 16'h0001);
            if (tmr_q == 16'h0001) begin
                tmr_run_d = 1'b0;
            end
        end
        if (i_reg_wr) begin
            case (i_reg_addr)
                dps_pkg::REG_CTRL:     ctrl_d  = i_reg_wdata & 8'h07;
                dps_pkg::REG_IRQ_STAT: ist_d   = ist_q & ~i_reg_wdata[IRQ_BITS_W-1:0];
                dps_pkg::REG_IRQ_MASK: imask_d = i_reg_wdata[IRQ_BITS_W-1:0];
                default:               ;
            endcase
        end
        // set after clear so a same-cycle event survives
        if (sif.gate_on && !gate_prev_q) begin
            ist_d[dps_pkg::IRQ_GATE_BIT] = 1'b1;
        end
        if (sif.go && !go_prev_q) begin
            ist_d[dps_pkg::IRQ_GO_BIT] = 1'b1;
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                dps_pkg::REG_CTRL:     rdata_d = ctrl_q;
                dps_pkg::REG_STATUS:   rdata_d = {4'h0, tmr_run_q, sif.go, sif.gate_on, mode_n};
                dps_pkg::REG_IRQ_STAT: rdata_d = {6'h00, ist_q};
                dps_pkg::REG_IRQ_MASK: rdata_d = {6'h00, imask_q};
                dps_pkg::REG_EXT_ADDR: rdata_d = ext_q;
                dps_pkg::REG_CMD:      rdata_d = cmd_q;
                default:               rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            ctrl_q      <= dps_pkg::CTRL_RESET;
            ext_q       <= 8'h00;
            cmd_q       <= 8'h00;
            ist_q       <= '0;
            imask_q     <= '0;
            rdata_q     <= 8'h00;
            rd_prev_q   <= 1'b1;
            div_q       <= 8'h00;
            tmr_q       <= 16'h0000;
            tmr_run_q   <= 1'b0;
            gate_prev_q <= 1'b0;
            go_prev_q   <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            ext_q       <= ext_d;
            cmd_q       <= cmd_d;
            ist_q       <= ist_d;
            imask_q     <= imask_d;
            rdata_q     <= rdata_d;
            rd_prev_q   <= rd_prev_d;
            div_q       <= div_d;
            tmr_q       <= tmr_d;
            tmr_run_q   <= tmr_run_d;
            gate_prev_q <= sif.gate_on;
            go_prev_q   <= sif.go;
        end
    end

    assign sif.mode_n    = mode_n;
    assign sif.phi2_tick = phi2_tick;
    assign sif.terminal  = terminal;

    dps_start u_start (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .s         (sif)
    );

    dps_chain #(.N(dps_pkg::NUM_SOURCES)) u_chain (
        .i_chain_in  (i_chain_priority_in),
        .i_pending   ({i_dma_irq, i_counter_timer_chip_irq, i_parallel_io_chip_irq}),
        .o_chain_out (o_chain_priority_out),
        .o_grant     ()
    );

    assign o_reg_rdata       = rdata_q;
    assign o_ext_addr        = ext_q;
    // gate bits only reach the drive while the start flop is set
    always_comb begin
        o_drive_cmd = cmd_q;
        o_drive_cmd[dps_pkg::CMD_READ_GATE]  = cmd_q[dps_pkg::CMD_READ_GATE] & sif.gate_on;
        o_drive_cmd[dps_pkg::CMD_WRITE_GATE] = cmd_q[dps_pkg::CMD_WRITE_GATE] & sif.gate_on;
    end
    assign o_status_buf_en   = sel_high && i_host_rd_n && porta0;
    assign o_write_to_disk   = !mode_n && ctrl_q[dps_pkg::CTRL_WRITE_BIT];
    assign o_read_from_disk  = !mode_n && !ctrl_q[dps_pkg::CTRL_WRITE_BIT];
    assign o_transfer_mode_n = mode_n;
    assign o_formatter_go    = sif.go;
    assign o_formatter_en    = o_write_to_disk || (o_read_from_disk && sif.go);
    assign o_bus_int_n       = !(i_dma_irq || i_counter_timer_chip_irq
                                 || i_parallel_io_chip_irq);
    assign o_irq             = |(ist_q & imask_q);
endmodule

// ===== hdl/dps_pkg.sv
// dps_pkg: constants shared by the disk port decode and start glue.
// assumes a single 50 MHz system clock and a plain register port.
package dps_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 20;
    localparam int unsigned PHI2_PERIOD_NS   = 250;
    localparam int unsigned PHI2_DIV_CYCLES  = (PHI2_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_TIME_US    = 12;
    localparam int unsigned TIMER_PHI2_TICKS = TIMER_TIME_US * 1000 / PHI2_PERIOD_NS;
    localparam logic [7:0]  PORT_LOW_ADDR    = 8'he0;
    localparam logic [7:0]  PORT_HIGH_ADDR   = 8'he1;
    localparam logic [7:0]  PORT_DEC_MASK    = 8'hfe;
    localparam logic [3:0]  REG_CTRL         = 4'h0;
    localparam logic [3:0]  REG_STATUS       = 4'h1;
    localparam logic [3:0]  REG_IRQ_STAT     = 4'h2;
    localparam logic [3:0]  REG_IRQ_MASK     = 4'h3;
    localparam logic [3:0]  REG_EXT_ADDR     = 4'h4;
    localparam logic [3:0]  REG_CMD          = 4'h5;
    localparam int unsigned CTRL_MODE_N_BIT  = 0;
    localparam int unsigned CTRL_WRITE_BIT   = 1;
    localparam int unsigned CTRL_PORTA0_BIT  = 2;
    localparam int unsigned CTRL_ARM_BIT     = 3;
    localparam logic [7:0]  CTRL_RESET       = 8'h01;
    localparam logic [7:0]  MASK_RESET       = 8'h00;
    localparam int unsigned CMD_READ_GATE    = 0;
    localparam int unsigned CMD_WRITE_GATE   = 1;
    localparam int unsigned IRQ_GATE_BIT     = 0;
    localparam int unsigned IRQ_GO_BIT       = 1;
    localparam int unsigned IRQ_BITS         = 2;
    localparam int unsigned NUM_SOURCES      = 3;
endpackage

// ===== hdl/dps_start_if.sv
// dps_start_if: start sequencer handshake between top and start module.
// assumes one clock domain; top drives the mode and tick, start module answers.
`timescale 1ns/10ps
interface dps_start_if;
    logic mode_n;
    logic phi2_tick;
    logic terminal;
    logic gate_on;
    logic go;
    modport top   (output mode_n, output phi2_tick, output terminal, input gate_on, input go);
    modport start (input mode_n, input phi2_tick, input terminal, output gate_on, output go);
endinterface

// ===== hdl/dps_start.sv
// dps_start: two-stage formatter start sequencer.
// assumes phi2_tick is a one-cycle pulse per host phase-2 edge.
`timescale 1ns/10ps
module dps_start (
    input  wire logic  i_clk_sys,
    input  wire logic  i_nrst,
    dps_start_if.start s
);
    logic first_q, first_d;
    logic second_q, second_d;

    always_comb begin
        first_d  = first_q;
        second_d = second_q;
        if (s.mode_n) begin
            first_d  = 1'b0;
            second_d = 1'b0;
        end else begin
            if (s.terminal) begin
                first_d = 1'b1;
            end
            if (s.phi2_tick) begin
                second_d = first_q;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            first_q  <= 1'b0;
            second_q <= 1'b0;
        end else begin
            first_q  <= first_d;
            second_q <= second_d;
        end
    end

    assign s.gate_on = first_q;
    assign s.go      = second_q;
endmodule

// ===== hdl/dps_chain.sv
// dps_chain: on-board interrupt priority chain of three sources.
// assumes source 0 highest; pending inputs are levels from each source.
`timescale 1ns/10ps
module dps_chain #(
    parameter int unsigned N = 3
) (
    input  wire logic         i_chain_in,
    input  wire logic [N-1:0] i_pending,
    output logic              o_chain_out,
    output logic [N-1:0]      o_grant
);
    logic [N:0] link;
    assign link[0] = i_chain_in;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_stage
            assign o_grant[g]  = link[g] & i_pending[g];
            assign link[g+1]   = link[g] & ~i_pending[g];
        end
    endgenerate
    assign o_chain_out = link[N];
endmodule

// ===== testbench/dps_monitor.sv
// dps_monitor: port-level checks on dps_top.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module dps_monitor #(
    parameter int unsigned TIMER_TICKS = dps_pkg::TIMER_PHI2_TICKS,
    parameter int unsigned PHI2_DIV    = dps_pkg::PHI2_DIV_CYCLES
) (
    input wire logic       i_clk_sys,
    input wire logic       i_nrst,
    input wire logic [7:0] i_host_addr,
    input wire logic [7:0] i_host_data,
    input wire logic       i_port_block_select_n,
    input wire logic       i_host_rd_n,
    input wire logic       i_chain_priority_in,
    input wire logic       i_dma_irq,
    input wire logic       i_counter_timer_chip_irq,
    input wire logic       i_parallel_io_chip_irq,
    input wire logic [7:0] o_ext_addr,
    input wire logic [7:0] o_drive_cmd,
    input wire logic       o_status_buf_en,
    input wire logic       o_read_from_disk,
    input wire logic       o_write_to_disk,
    input wire logic       o_transfer_mode_n,
    input wire logic       o_formatter_go,
    input wire logic       o_formatter_en,
    input wire logic       o_bus_int_n,
    input wire logic       o_chain_priority_out
);
    localparam int GO_WAIT = PHI2_DIV + 1;
    wire any_irq = i_dma_irq | i_counter_timer_chip_irq | i_parallel_io_chip_irq;
    wire at_low  = !i_port_block_select_n && (i_host_addr == dps_pkg::PORT_LOW_ADDR);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    a_int_wired_or: assert property (o_bus_int_n == !any_irq)
        else $error("bus interrupt line wrong");
    a_chain_block: assert property (!i_chain_priority_in || any_irq |-> !o_chain_priority_out)
        else $error("chain out high while blocked");
    a_chain_pass: assert property (i_chain_priority_in && !any_irq |-> o_chain_priority_out)
        else $error("chain out low while idle");
    a_fmt_enable: assert property (o_formatter_en ==
        (o_write_to_disk || (o_read_from_disk && o_formatter_go)))
        else $error("formatter enable wrong");
    a_one_direction: assert property ((o_read_from_disk ^ o_write_to_disk) == !o_transfer_mode_n)
        else $error("direction select wrong");
    a_idle_clears: assert property (o_transfer_mode_n && $past(o_transfer_mode_n) |->
        !o_formatter_go && o_drive_cmd[1:0] == 2'h0)
        else $error("start flops not cleared");
    a_go_follows: assert property ($rose(o_drive_cmd[0]) |-> ##[0:GO_WAIT] o_formatter_go)
        else $error("formatter go late");
    a_ext_latch: assert property ($fell(i_host_rd_n) && at_low |=> o_ext_addr == $past(i_host_data))
        else $error("extended address not latched");
    a_ext_ignore: assert property ($fell(i_host_rd_n) && !at_low |=> $stable(o_ext_addr))
        else $error("extended address changed");
    a_status_cond: assert property (o_status_buf_en |-> !i_port_block_select_n && i_host_rd_n
        && i_host_addr == dps_pkg::PORT_HIGH_ADDR)
        else $error("status enable outside upper port");
    c_gate: cover property ($rose(o_drive_cmd[0]));
    c_go: cover property ($rose(o_formatter_go));
    c_latch: cover property ($fell(i_host_rd_n) && at_low);
endmodule
bind dps_top dps_monitor #(.TIMER_TICKS(TIMER_TICKS), .PHI2_DIV(PHI2_DIV)) u_mon (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_host_addr(i_host_addr),
    .i_host_data(i_host_data), .i_port_block_select_n(i_port_block_select_n),
    .i_host_rd_n(i_host_rd_n), .i_chain_priority_in(i_chain_priority_in),
    .i_dma_irq(i_dma_irq), .i_counter_timer_chip_irq(i_counter_timer_chip_irq),
    .i_parallel_io_chip_irq(i_parallel_io_chip_irq), .o_ext_addr(o_ext_addr),
    .o_drive_cmd(o_drive_cmd), .o_status_buf_en(o_status_buf_en),
    .o_read_from_disk(o_read_from_disk), .o_write_to_disk(o_write_to_disk),
    .o_transfer_mode_n(o_transfer_mode_n), .o_formatter_go(o_formatter_go),
    .o_formatter_en(o_formatter_en), .o_bus_int_n(o_bus_int_n),
    .o_chain_priority_out(o_chain_priority_out));

// ===== testbench/dps_host_model.sv
// dps_host_model: host i/o cycles toward the port decoder.
// assumes tasks are entered just after a rising edge.
`timescale 1ns/10ps
module dps_host_model (
    input  wire logic  i_clk_sys,
    output logic [7:0] o_addr,
    output logic [7:0] o_data,
    output logic       o_sel_n,
    output logic       o_rd_n
);
    initial begin
        o_addr = 8'h00;
        o_data = 8'h00;
        o_sel_n = 1'b1;
        o_rd_n = 1'b1;
    end
    task automatic step;
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic place(input logic [7:0] a, input logic [7:0] d);
        o_addr <= a;
        o_data <= d;
        o_sel_n <= 1'b0;
        step;
    endtask
    task automatic strobe;
        o_rd_n <= 1'b0;
        step;
        step;
        o_rd_n <= 1'b1; // back high before the next latch
    endtask
    task automatic release_bus;
        o_sel_n <= 1'b1;
        o_addr <= ~o_addr; // no stale value once released
        o_data <= ~o_data;
        step;
    endtask
endmodule

// ===== testbench/tb.sv
// tb: self-checking bench for dps_top.
// assumes the host model and monitor are compiled alongside.
`timescale 1ns/10ps
module tb;
    localparam int unsigned DIV = 2;
    logic       clk;
    logic       nrst;
    logic       chain_in;
    logic [2:0] irq;
    logic [3:0] ra;
    logic [7:0] wd;
    logic       wr;
    logic       rd;
    logic [7:0] h_addr;
    logic [7:0] h_data;
    logic       h_sel_n;
    logic       h_rd_n;
    logic [7:0] rdata;
    logic [7:0] ext;
    logic [7:0] cmd;
    logic       sbe;
    logic       rfd;
    logic       wtd;
    logic       mode_n;
    logic       go;
    logic       fen;
    logic       int_n;
    logic       chain_out;
    logic       irq_out;
    int         err_total = 0;
    int         comparisons = 0;
    int         cyc = 0;
    dps_host_model u_host (.i_clk_sys(clk), .o_addr(h_addr), .o_data(h_data),
        .o_sel_n(h_sel_n), .o_rd_n(h_rd_n));
    dps_top #(.TIMER_TICKS(2), .PHI2_DIV(DIV)) u_dut (.i_clk_sys(clk), .i_nrst(nrst),
        .i_host_addr(h_addr), .i_host_data(h_data), .i_port_block_select_n(h_sel_n),
        .i_host_rd_n(h_rd_n), .i_chain_priority_in(chain_in), .i_dma_irq(irq[0]),
        .i_counter_timer_chip_irq(irq[1]), .i_parallel_io_chip_irq(irq[2]),
        .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_ext_addr(ext), .o_drive_cmd(cmd), .o_status_buf_en(sbe),
        .o_read_from_disk(rfd), .o_write_to_disk(wtd), .o_transfer_mode_n(mode_n),
        .o_formatter_go(go), .o_formatter_en(fen), .o_bus_int_n(int_n),
        .o_chain_priority_out(chain_out), .o_irq(irq_out));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            test_done;
        end
    end
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        tick;
        wr <= 1'b0;
        tick;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e);
        ra <= a;
        rd <= 1'b1;
        tick;
        rd <= 1'b0;
        chk($sformatf("reg %h", a), e, rdata);
        tick;
    endtask
    task automatic host(input logic [7:0] a, input logic [7:0] d);
        u_host.place(a, d);
        u_host.strobe;
        u_host.release_bus;
    endtask
    task automatic t_reset;
        wreg(4'hf, 8'hff);
        rreg(4'hf, 8'h00);
        rreg(dps_pkg::REG_CTRL, dps_pkg::CTRL_RESET);
        rreg(dps_pkg::REG_IRQ_MASK, dps_pkg::MASK_RESET);
        chk("mode", 8'h01, 8'(mode_n));
    endtask
    task automatic t_cmd;
        wreg(dps_pkg::REG_CTRL, 8'h00);
        host(dps_pkg::PORT_HIGH_ADDR, 8'hf0);
        chk("cmd", 8'h00, cmd);
        wreg(dps_pkg::REG_CTRL, 8'h04);
        host(dps_pkg::PORT_HIGH_ADDR, 8'hc3);
        chk("cmd", 8'hc0, cmd);
    endtask
    task automatic t_decode;
        host(dps_pkg::PORT_LOW_ADDR, 8'h5a);
        chk("ext", 8'h5a, ext);
        rreg(dps_pkg::REG_EXT_ADDR, 8'h5a);
        for (int i = 0; i < 3; i++) begin
            host(8'he0 | (8'h02 << i), 8'h33);
            chk("ext", 8'h5a, ext);
        end
        u_host.place(dps_pkg::PORT_HIGH_ADDR, 8'h00);
        chk("sbe", 8'h01, 8'(sbe));
        u_host.release_bus;
        chk("sbe", 8'h00, 8'(sbe));
    endtask
    task automatic t_start;
        int n;
        n = 0;
        wreg(dps_pkg::REG_CTRL, 8'h0c);
        while (cmd[0] !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        chk("cmd", 8'hc3, cmd);
        chk("go", 8'h00, 8'(go));
        repeat (DIV + 1) tick;
        chk("go", 8'h01, 8'(go));
        chk("fen", 8'h01, 8'(fen));
        rreg(dps_pkg::REG_STATUS, 8'h06);
        rreg(dps_pkg::REG_CMD, 8'hc3);
        rreg(dps_pkg::REG_IRQ_STAT, 8'h03);
        chk("irq", 8'h00, 8'(irq_out));
        wreg(dps_pkg::REG_IRQ_MASK, 8'h01);
        chk("irq", 8'h01, 8'(irq_out));
        wreg(dps_pkg::REG_IRQ_STAT, 8'h01);
        rreg(dps_pkg::REG_IRQ_STAT, 8'h02);
        chk("irq", 8'h00, 8'(irq_out));
    endtask
    task automatic t_stop;
        wreg(dps_pkg::REG_CTRL, 8'h05);
        tick;
        chk("go", 8'h00, 8'(go));
        chk("cmd", 8'hc0, cmd);
        chk("dir", 8'h00, 8'({rfd, wtd}));
        wreg(dps_pkg::REG_CTRL, 8'h06);
        chk("dir", 8'h01, 8'({rfd, wtd}));
        chk("fen", 8'h01, 8'(fen));
        chk("cmd", 8'hc0, cmd);
    endtask
    task automatic t_chain;
        for (int i = 0; i < 3; i++) begin
            irq <= 3'b001 << i;
            tick;
            chk("int", 8'h00, 8'(int_n));
            chk("chain", 8'h00, 8'(chain_out));
        end
        irq <= 3'b000;
        tick;
        chk("int", 8'h01, 8'(int_n));
        chk("chain", 8'h01, 8'(chain_out));
        chain_in <= 1'b0;
        tick;
        chk("chain", 8'h00, 8'(chain_out));
    endtask
    initial begin
        nrst = 1'b0;
        chain_in = 1'b1;
        irq = 3'b000;
        ra = 4'h0;
        wd = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (3) tick;
        nrst <= 1'b1;
        tick;
        t_reset;
        t_cmd;
        t_decode;
        t_start;
        t_stop;
        t_chain;
        test_done;
    end
endmodule
